// >>> inc/ohi_map.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 20 MHz system clock
// Notes: overhead positions are zero-based row and column indices
`ifndef OHI_MAP_SVH
`define OHI_MAP_SVH
`define OHI_CLK_NS 50
`define OHI_USER_BIT_NS 15625
`define OHI_DCC_BIT_NS 1736
`define OHI_VC3_COLS 9'd87
`define OHI_VC4_COLS 9'd261
`define OHI_J0_COL_STM0 4'd2
`define OHI_J0_COL_STM1 4'd6
`define OHI_POH_J1 4'd0
`define OHI_POH_B3 4'd1
`define OHI_POH_C2 4'd2
`define OHI_POH_G1 4'd3
`define OHI_POH_F2 4'd4
`define OHI_POH_F3 4'd6
`define OHI_POH_K3 4'd7
`define OHI_POH_NONE 4'd9
`define OHI_ROW_K 4'd4
`define OHI_ROW_D_FIRST 4'd5
`define OHI_ROW_D_LAST 4'd7
`define OHI_ROW_S1 4'd8
`define OHI_COL_K1 4'd1
`define OHI_COL_K2 4'd2
`define OHI_COL_S1 4'd0
`define OHI_SER_K1 4'd0
`define OHI_SER_K2 4'd1
`define OHI_SER_S1 4'd2
`define OHI_K2_RDI 3'b110
`define OHI_K2_OK 3'b000
`define OHI_PAR_ODD 1'b1
`define OHI_TRACE_LAST16 6'd15
`define OHI_TRACE_LAST64 6'd63
`define OHI_CFG_RST '0
`endif

// >>> inc/ohi_pkg.sv
// Purpose: types shared by the transmit overhead inserter
// Assumes: nothing beyond the map header
// Notes: every source select resets to zero, meaning register source, or the serial channel for F2/F3 and DCC
`default_nettype none
package ohi_pkg;
	typedef struct packed {
		logic stm1;
		logic j1_len64;
		logic j1_src_ser;
		logic c2_src_ser;
		logic g1_src_ser;
		logic g1_auto;
		logic k3_src_ser;
		logic b3_inv;
		logic uneq_en;
		logic fch_src_rx;
		logic k_src_ser;
		logic k2_auto;
		logic dcc_src_rx;
		logic s1_src_ser;
		logic protect_master;
	} ohi_cfg_s;
	typedef struct packed {
		logic [7:0] c2;
		logic [7:0] g1;
		logic [7:0] k3;
		logic [7:0] k1;
		logic [7:0] k2;
		logic [7:0] s1;
	} ohi_ohreg_s;
	typedef struct packed {
		logic [7:0] f2;
		logic [7:0] f3;
		logic [7:0] dcc;
		logic [3:0] rei;
		logic rdi;
		logic ms_rdi;
	} ohi_rx_s;
	typedef struct packed {
		logic [7:0] data;
		logic frm;
		logic pay;
		logic [3:0] row;
		logic [3:0] col;
		logic ok;
	} ohi_byte_s;
endpackage : ohi_pkg
`default_nettype wire

// >>> logic/ohi_chan.sv
// Purpose: serial channel with self made bit clock and byte sync
// Assumes: bit input already synchronised to clock
// Notes: bit taken at bit clock rising edge, msb first
`timescale 1ns/10ps
`default_nettype none
module ohi_chan #(
	parameter int HALF = 156
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic bit_in,
	output logic bit_clk,
	output logic byte_sync,
	output logic [7:0] byte_q
);
	localparam logic [8:0] LAST = 9'(HALF - 1);
	logic [8:0] cnt_q;
	logic clk_q;
	logic sync_q;
	logic [2:0] bitn_q;
	logic [6:0] sh_q;
	wire tick = cnt_q == LAST;
	wire rise = tick & ~clk_q;

	// divider and shifter; sync spans bit 0 of each byte
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			cnt_q <= '0;
			clk_q <= 1'b0;
			sync_q <= 1'b0;
			bitn_q <= '0;
			sh_q <= '0;
			byte_q <= '0;
		end
		else
		begin
			cnt_q <= tick ? 9'd0 : cnt_q + 9'd1;
			if (tick)
				clk_q <= ~clk_q;
			if (rise)
			begin
				sh_q <= {sh_q[5:0], bit_in};
				bitn_q <= bitn_q + 3'd1;
				sync_q <= bitn_q == 3'd7;
				if (bitn_q == 3'd7)
					byte_q <= {sh_q, bit_in};
			end
		end
	end

	assign bit_clk = clk_q;
	assign byte_sync = sync_q;
endmodule : ohi_chan
`default_nettype wire

// >>> logic/ohi_deser.sv
// Purpose: serial overhead input gathered into bytes indexed from sync
// Assumes: one bit per strobe, msb first, sync on bit 0 of byte 0
// Notes: holds the last sixteen bytes of the frame for insertion
`timescale 1ns/10ps
`default_nettype none
module ohi_deser (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic stb,
	input wire logic sync,
	input wire logic bit_in,
	input wire logic [3:0] rd_idx,
	output logic [7:0] rd_byte
);
	logic [6:0] sh_q;
	logic [2:0] bitn_q;
	logic [3:0] idx_q;
	logic [7:0] mem [16];
	wire [2:0] bitn = sync ? 3'd0 : bitn_q;
	wire [3:0] idx = sync ? 4'd0 : idx_q;

	// shift and count; sync restarts byte zero
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			sh_q <= '0;
			bitn_q <= '0;
			idx_q <= '0;
		end
		else if (stb)
		begin
			sh_q <= {sh_q[5:0], bit_in};
			bitn_q <= bitn + 3'd1;
			if (bitn == 3'd7)
				idx_q <= idx + 4'd1;
			else
				idx_q <= idx;
		end
	end

	// storage holds no reset; stale bytes only until first frame
	always_ff @(posedge clock)
	begin
		if (stb && bitn == 3'd7)
			mem[idx] <= {sh_q, bit_in};
	end

	assign rd_byte = mem[rd_idx];
endmodule : ohi_deser
`default_nettype wire

// >>> logic/ohi_tx_inserter.sv
// Purpose: transmit path, path overhead, adaptation, section overhead
// Assumes: bus data changes on the falling bus clock edge
// Notes: bus clock is sampled, so it must stay below a quarter of clock
`timescale 1ns/10ps
`default_nettype none
`include "ohi_map.svh"
// Contract
// - byte data with clock, marker, payload active
// - parity checked on every bus byte
// - J1 trace repeats 16 or 64 bytes
// - B3 computed and inserted, optional inversion
// - C2 from register or serial input
// - G1 from register, serial, or receive side
// - F2/F3 from serial channels or receive side
// - K3 from register or serial input
// - unequipped payload replaces data when enabled
// - pointer re-timing counts positive, negative events
// - protection master forwards adapted stream
// - section overhead follows path overhead, adaptation
// - K1/K2 from register or serial input
// - automatic remote defect overrides K2 low bits
// - D4-D12 from 576 KHz serial or received
// - S1 from register or serial input
// - master drives protection clock, times section serial
// - master drives frame pulse at J0
module ohi_tx_inserter (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] tx_bus_data,
	input wire logic tx_bus_clock,
	input wire logic tx_bus_frame_marker,
	input wire logic tx_bus_payload_active,
	input wire logic tx_bus_parity,
	input wire ohi_pkg::ohi_cfg_s cfg,
	input wire ohi_pkg::ohi_ohreg_s oh_regs,
	input wire ohi_pkg::ohi_rx_s rx,
	input wire logic trace_wr_en,
	input wire logic [5:0] trace_wr_addr,
	input wire logic [7:0] trace_wr_data,
	input wire logic path_oh_serial_in,
	input wire logic path_user_channel1_in,
	input wire logic path_user_channel2_in,
	output logic path_user_bit_clock,
	output logic path_user_byte_sync,
	input wire logic section_oh_serial_in,
	input wire logic mux_dcc_serial_in,
	output logic mux_dcc_clock,
	input wire logic [7:0] protect_tx_data_in,
	output logic [7:0] protect_tx_data,
	output logic protect_tx_data_oe,
	input wire logic protect_tx_frame_pulse_in,
	output logic protect_tx_frame_pulse,
	output logic protect_tx_frame_pulse_oe,
	output logic protect_tx_clock_out,
	output logic [7:0] out_data,
	output logic out_frame,
	output logic out_payload,
	output logic out_valid,
	output logic parity_error,
	output logic [15:0] pj_pos_count,
	output logic [15:0] pj_neg_count
);
	import ohi_pkg::*;

	localparam int USER_HALF = `OHI_USER_BIT_NS / (2 * `OHI_CLK_NS);
	localparam int DCC_HALF = `OHI_DCC_BIT_NS / (2 * `OHI_CLK_NS);

	ohi_cfg_s cfg_q;
	logic clk_s1_q, clk_s2_q, clk_s3_q;
	logic [10:0] bus_s1_q, bus_s2_q;
	logic [4:0] ser_s1_q, ser_s2_q;
	logic pay_prev_q;
	logic [3:0] row_q, col_q, poh_idx_q;
	logic [8:0] pay_cnt_q;
	logic [5:0] trace_ptr_q;
	logic [7:0] trace_mem [64];
	logic [7:0] acc_q, bip_q;
	ohi_byte_s s1_q, s2_q;
	logic s1_vld_q, s2_vld_q;
	logic [11:0] off_q, last_off_q;
	logic have_off_q;
	logic par_err_q;
	logic [7:0] out_data_q;
	logic out_frame_q, out_pay_q, out_vld_q;
	logic [15:0] pos_q, neg_q;
	logic [7:0] path_ser_byte, sect_ser_byte;
	logic [7:0] f2_byte, f3_byte, dcc_byte;

	// latched controls give the defined reset state
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			cfg_q <= `OHI_CFG_RST;
		else
			cfg_q <= cfg;
	end

	// two flops on every pin from the bus and serial inputs
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			{clk_s1_q, clk_s2_q, clk_s3_q} <= '0;
			{bus_s1_q, bus_s2_q} <= '0;
			{ser_s1_q, ser_s2_q} <= '0;
		end
		else
		begin
			clk_s1_q <= tx_bus_clock;
			clk_s2_q <= clk_s1_q;
			clk_s3_q <= clk_s2_q;
			bus_s1_q <= {tx_bus_data, tx_bus_parity, tx_bus_frame_marker,
				tx_bus_payload_active};
			bus_s2_q <= bus_s1_q;
			// user channel pins are asynchronous too, so they ride along
			ser_s1_q <= {path_user_channel1_in, path_user_channel2_in,
				path_oh_serial_in, section_oh_serial_in, mux_dcc_serial_in};
			ser_s2_q <= ser_s1_q;
		end
	end

	// byte strobe on the sampled bus clock rising edge
	wire stb = clk_s2_q & ~clk_s3_q;
	wire [7:0] in_data = bus_s2_q[10:3];
	wire in_par = bus_s2_q[2];
	wire in_frm = bus_s2_q[1];
	wire in_pay = bus_s2_q[0];
	wire is_j0 = in_frm & ~in_pay;
	wire is_j1 = in_frm & in_pay;
	wire par_bad = (^{in_data, in_par}) != `OHI_PAR_ODD;

	// position in the frame: section rows and overhead columns
	wire new_row = ~in_pay & pay_prev_q;
	wire [3:0] j0_col = cfg_q.stm1 ? `OHI_J0_COL_STM1 : `OHI_J0_COL_STM0;
	wire [3:0] cur_col = is_j0 ? j0_col : (new_row ? 4'd0 : col_q);
	wire [3:0] cur_row = is_j0 ? 4'd0 : (new_row ? row_q + 4'd1 : row_q);
	wire [3:0] oh_col = cfg_q.stm1 ? cur_col / 4'd3 : cur_col;
	wire oh_ok = ~cfg_q.stm1 | (cur_col % 4'd3 == 4'd0);

	// path overhead column recurs every vc row of payload bytes
	wire [8:0] vc_cols = cfg_q.stm1 ? `OHI_VC4_COLS : `OHI_VC3_COLS;
	wire [3:0] poh_slot = is_j1 ? `OHI_POH_J1 :
		(in_pay && pay_cnt_q == 9'd0) ? poh_idx_q : `OHI_POH_NONE;
	wire [5:0] trace_last = cfg_q.j1_len64 ? `OHI_TRACE_LAST64 :
		`OHI_TRACE_LAST16;

	// path overhead byte sources
	wire [7:0] j1_byte = cfg_q.j1_src_ser ? path_ser_byte :
		trace_mem[trace_ptr_q];
	wire [7:0] b3_byte = bip_q ^ {8{cfg_q.b3_inv}};
	wire [7:0] c2_byte = cfg_q.c2_src_ser ? path_ser_byte :
		oh_regs.c2;
	wire [7:0] g1_byte = cfg_q.g1_auto ? {rx.rei, rx.rdi, oh_regs.g1[2:0]} :
		(cfg_q.g1_src_ser ? path_ser_byte : oh_regs.g1);
	wire [7:0] f2_ins = cfg_q.fch_src_rx ? rx.f2 : f2_byte;
	wire [7:0] f3_ins = cfg_q.fch_src_rx ? rx.f3 : f3_byte;
	wire [7:0] k3_byte = cfg_q.k3_src_ser ? path_ser_byte :
		oh_regs.k3;
	wire [7:0] poh_ins = (poh_slot == `OHI_POH_J1) ? j1_byte :
		(poh_slot == `OHI_POH_B3) ? b3_byte :
		(poh_slot == `OHI_POH_C2) ? c2_byte :
		(poh_slot == `OHI_POH_G1) ? g1_byte :
		(poh_slot == `OHI_POH_F2) ? f2_ins :
		(poh_slot == `OHI_POH_F3) ? f3_ins :
		(poh_slot == `OHI_POH_K3) ? k3_byte : in_data;
	// unequipped zeroes the payload but keeps the overhead just built
	wire [7:0] s0_data = (cfg_q.uneq_en && in_pay &&
		poh_slot == `OHI_POH_NONE) ? 8'h00 : poh_ins;

	// frame position counters, advanced once per bus byte
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			pay_prev_q <= 1'b0;
			row_q <= '0;
			col_q <= '0;
			pay_cnt_q <= 9'd1;
			poh_idx_q <= `OHI_POH_NONE;
		end
		else if (stb)
		begin
			pay_prev_q <= in_pay;
			if (!in_pay)
			begin
				row_q <= cur_row;
				col_q <= cur_col + 4'd1;
			end
			else if (is_j1)
			begin
				pay_cnt_q <= 9'd1;
				poh_idx_q <= `OHI_POH_J1;
			end
			else if (pay_cnt_q == vc_cols - 9'd1)
			begin
				pay_cnt_q <= 9'd0;
				if (poh_idx_q != `OHI_POH_NONE)
					poh_idx_q <= poh_idx_q + 4'd1;
			end
			else
				pay_cnt_q <= pay_cnt_q + 9'd1;
		end
	end

	// trace string pointer and running path parity
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			trace_ptr_q <= '0;
			acc_q <= '0;
			bip_q <= '0;
			par_err_q <= 1'b0;
		end
		else
		begin
			par_err_q <= stb & par_bad;
			if (stb && is_j1)
				trace_ptr_q <= (trace_ptr_q >= trace_last) ? 6'd0 :
					trace_ptr_q + 6'd1;
			if (stb && is_j1)
			begin
				bip_q <= acc_q;
				acc_q <= s0_data;
			end
			else if (stb && in_pay)
				acc_q <= acc_q ^ s0_data;
		end
	end

	// trace storage written by software; index 0 is the check byte
	always_ff @(posedge clock)
	begin
		if (trace_wr_en)
			trace_mem[trace_wr_addr] <= trace_wr_data;
	end

	// pipeline: path stage, adaptation stage, section stage
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s1_vld_q <= 1'b0;
			s2_vld_q <= 1'b0;
		end
		else
		begin
			s1_vld_q <= stb;
			s2_vld_q <= s1_vld_q;
			if (stb)
				s1_q <= '{data: s0_data, frm: in_frm, pay: in_pay,
					row: cur_row, col: oh_col, ok: oh_ok};
			if (s1_vld_q)
				s2_q <= s1_q;
		end
	end

	// justification seen as the J1 offset from J0 moving
	wire s1_j0 = s1_q.frm & ~s1_q.pay;
	wire s1_j1 = s1_q.frm & s1_q.pay;
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			off_q <= '0;
			last_off_q <= '0;
			have_off_q <= 1'b0;
			pos_q <= '0;
			neg_q <= '0;
		end
		else if (s1_vld_q)
		begin
			off_q <= s1_j0 ? 12'd1 : off_q + 12'd1;
			if (s1_j1)
			begin
				last_off_q <= off_q;
				have_off_q <= 1'b1;
				if (have_off_q && off_q > last_off_q)
					pos_q <= pos_q + 16'd1;
				if (have_off_q && off_q < last_off_q)
					neg_q <= neg_q + 16'd1;
			end
		end
	end

	// section overhead slots on the adapted stream
	wire ms_oh = ~s2_q.pay & s2_q.ok;
	wire k1_hit = ms_oh && s2_q.row == `OHI_ROW_K && s2_q.col == `OHI_COL_K1;
	wire k2_hit = ms_oh && s2_q.row == `OHI_ROW_K && s2_q.col == `OHI_COL_K2;
	wire d_hit = ms_oh && s2_q.row >= `OHI_ROW_D_FIRST &&
		s2_q.row <= `OHI_ROW_D_LAST;
	wire s1_hit = ms_oh && s2_q.row == `OHI_ROW_S1 &&
		s2_q.col == `OHI_COL_S1;
	wire [3:0] sect_idx = k1_hit ? `OHI_SER_K1 :
		(k2_hit ? `OHI_SER_K2 : `OHI_SER_S1);
	wire [7:0] k1_byte = cfg_q.k_src_ser ? sect_ser_byte :
		oh_regs.k1;
	wire [7:0] k2_src = cfg_q.k_src_ser ? sect_ser_byte :
		oh_regs.k2;
	wire [2:0] k2_low = cfg_q.k2_auto ?
		(rx.ms_rdi ? `OHI_K2_RDI : `OHI_K2_OK) : k2_src[2:0];
	wire [7:0] d_byte = cfg_q.dcc_src_rx ? rx.dcc : dcc_byte;
	wire [7:0] s1_byte = cfg_q.s1_src_ser ? sect_ser_byte :
		oh_regs.s1;
	wire [7:0] ms_data = k1_hit ? k1_byte :
		k2_hit ? {k2_src[7:3], k2_low} :
		d_hit ? d_byte :
		s1_hit ? s1_byte : s2_q.data;

	// output register, loaded only after the two earlier stages
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			out_data_q <= '0;
			out_frame_q <= 1'b0;
			out_pay_q <= 1'b0;
			out_vld_q <= 1'b0;
		end
		else
		begin
			out_vld_q <= s2_vld_q;
			if (s2_vld_q)
			begin
				out_data_q <= ms_data;
				out_frame_q <= s2_q.frm;
				out_pay_q <= s2_q.pay;
			end
		end
	end

	// serial overhead feeds, bit per bus byte, timed like the port clock
	ohi_deser u_path_ser (
		.clock(clock),
		.rst_n(rst_n),
		.stb(stb),
		.sync(is_j1),
		.bit_in(ser_s2_q[2]),
		.rd_idx(poh_slot),
		.rd_byte(path_ser_byte)
	);
	ohi_deser u_sect_ser (
		.clock(clock),
		.rst_n(rst_n),
		.stb(stb),
		.sync(is_j0),
		.bit_in(ser_s2_q[1]),
		.rd_idx(sect_idx),
		.rd_byte(sect_ser_byte)
	);

	// user channels share the first instance's clock and sync
	ohi_chan #(.HALF(USER_HALF)) u_f2 (
		.clock(clock),
		.rst_n(rst_n),
		.bit_in(ser_s2_q[4]),
		.bit_clk(path_user_bit_clock),
		.byte_sync(path_user_byte_sync),
		.byte_q(f2_byte)
	);
	ohi_chan #(.HALF(USER_HALF)) u_f3 (
		.clock(clock),
		.rst_n(rst_n),
		.bit_in(ser_s2_q[3]),
		.bit_clk(),
		.byte_sync(),
		.byte_q(f3_byte)
	);
	ohi_chan #(.HALF(DCC_HALF)) u_dcc (
		.clock(clock),
		.rst_n(rst_n),
		.bit_in(ser_s2_q[0]),
		.bit_clk(mux_dcc_clock),
		.byte_sync(),
		.byte_q(dcc_byte)
	);

	// protection port: adapted stream before section overhead
	assign protect_tx_data = s2_q.data;
	assign protect_tx_data_oe = cfg_q.protect_master;
	assign protect_tx_frame_pulse = s2_q.frm & ~s2_q.pay;
	assign protect_tx_frame_pulse_oe = cfg_q.protect_master;
	// clock follows the bus byte rate; slave inputs are unused here
	assign protect_tx_clock_out = clk_s3_q & cfg_q.protect_master;

	assign out_data = out_data_q;
	assign out_frame = out_frame_q;
	assign out_payload = out_pay_q;
	assign out_valid = out_vld_q;
	assign parity_error = par_err_q;
	assign pj_pos_count = pos_q;
	assign pj_neg_count = neg_q;
endmodule : ohi_tx_inserter
`default_nettype wire

// >>> test/ohi_mapper_model.sv
// Purpose: mapper side of the transmit bus, one 810-byte frame loop
// Assumes: bus clock of 8 system clocks, data moves on its fall
// Notes: byte value is column plus sixteen times row
`timescale 1ns/10ps
`default_nettype none
module ohi_mapper_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [6:0] j1_col,
	input wire logic bad_par,
	output logic [7:0] tx_bus_data,
	output logic tx_bus_clock,
	output logic tx_bus_frame_marker,
	output logic tx_bus_payload_active,
	output logic tx_bus_parity,
	output logic ser_bit
);
	logic [2:0] ph_q;
	logic [6:0] col_q, j1_q;
	logic [3:0] row_q;
	logic bad_q;
	// pointer move taken only at frame start, never two J1 markers in one frame
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			ph_q <= 3'h0;
			col_q <= 7'h00;
			row_q <= 4'h0;
			j1_q <= 7'h03;
			bad_q <= 1'b0;
		end
		else
		begin
			ph_q <= ph_q + 3'h1;
			if (ph_q == 3'h7)
			begin
				bad_q <= bad_par;
				col_q <= (col_q == 7'h59) ? 7'h00 : col_q + 7'h01;
				if (col_q == 7'h59)
					row_q <= (row_q == 4'h8) ? 4'h0 : row_q + 4'h1;
				if (col_q == 7'h59 && row_q == 4'h8)
					j1_q <= j1_col;
			end
		end
	end
	// bus lines all derive from registers
	assign tx_bus_clock = ph_q[2];
	assign tx_bus_data = {1'b0, col_q} + {row_q, 4'h0};
	assign tx_bus_payload_active = (col_q > 7'h02);
	assign tx_bus_frame_marker = (row_q == 4'h0) &&
		(col_q == 7'h02 || col_q == j1_q);
	assign tx_bus_parity = ~(^tx_bus_data) ^ bad_q;
	assign ser_bit = tx_bus_data[0];
endmodule : ohi_mapper_model
`default_nettype wire

// >>> test/ohi_tx_checker.sv
// Purpose: port checks on the transmit overhead inserter
// Assumes: bus clock period of exactly 8 clocks
// Notes: clock dividers are checked by half-period counters
`timescale 1ns/10ps
`default_nettype none
module ohi_tx_checker
	import ohi_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic tx_bus_clock,
	input wire logic [7:0] tx_bus_data,
	input wire logic tx_bus_parity,
	input wire ohi_pkg::ohi_cfg_s cfg,
	input wire logic out_valid,
	input wire logic parity_error,
	input wire logic protect_tx_data_oe,
	input wire logic protect_tx_frame_pulse,
	input wire logic protect_tx_frame_pulse_oe,
	input wire logic protect_tx_clock_out,
	input wire logic path_user_bit_clock,
	input wire logic path_user_byte_sync,
	input wire logic mux_dcc_clock,
	input wire logic [15:0] pj_pos_count,
	input wire logic [15:0] pj_neg_count
);
	logic bc_q, dc_q, bc_arm_q, dc_arm_q;
	logic [8:0] bc_cnt_q, dc_cnt_q;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// arm only after a first edge, so reset never fakes a short half
	always_ff @(posedge clock)
	begin
		bc_q <= path_user_bit_clock;
		dc_q <= mux_dcc_clock;
		bc_cnt_q <= (bc_q != path_user_bit_clock) ? 9'h001 : bc_cnt_q + 9'h001;
		dc_cnt_q <= (dc_q != mux_dcc_clock) ? 9'h001 : dc_cnt_q + 9'h001;
		bc_arm_q <= rst_n & (bc_arm_q | (bc_q != path_user_bit_clock));
		dc_arm_q <= rst_n & (dc_arm_q | (dc_q != mux_dcc_clock));
	end
	sequence bus_byte;
		$rose(tx_bus_clock);
	endsequence
	sequence master_held;
		cfg.protect_master [*3];
	endsequence
	chk_byte_answered: assert property (bus_byte |-> ##[2:6] out_valid)
		else $error("no output byte after a bus byte");
	chk_valid_pulse: assert property (out_valid |=> !out_valid [*4])
		else $error("output strobe longer than one cycle");
	chk_parity_flag: assert property (
		bus_byte ##0 !(^{tx_bus_data, tx_bus_parity}) |-> ##[1:5] parity_error)
		else $error("bad parity not flagged");
	chk_parity_quiet: assert property (
		bus_byte ##0 (^{tx_bus_data, tx_bus_parity}) |-> ##1 !parity_error [*6])
		else $error("parity flagged on a good byte");
	chk_master_drives: assert property (
		master_held |-> protect_tx_data_oe && protect_tx_frame_pulse_oe)
		else $error("protection port not driven as master");
	chk_slave_quiet: assert property ((!cfg.protect_master) [*3] |->
		!protect_tx_data_oe && !protect_tx_frame_pulse_oe && !protect_tx_clock_out)
		else $error("protection port driven while not master");
	chk_pulse_width: assert property ($rose(protect_tx_frame_pulse) |->
		protect_tx_frame_pulse [*8] ##1 !protect_tx_frame_pulse)
		else $error("frame pulse not one byte long");
	chk_bit_clock_half: assert property (
		bc_arm_q && (bc_q != path_user_bit_clock) |-> bc_cnt_q == 9'h09c)
		else $error("user bit clock half period wrong");
	chk_dcc_clock_half: assert property (
		dc_arm_q && (dc_q != mux_dcc_clock) |-> dc_cnt_q == 9'h011)
		else $error("data channel clock half period wrong");
	chk_sync_on_rise: assert property (
		$changed(path_user_byte_sync) |-> $rose(path_user_bit_clock))
		else $error("user byte sync moved off a bit clock rise");
	chk_count_reset: assert property (
		$rose(rst_n) |-> pj_pos_count == 16'h0000 && pj_neg_count == 16'h0000)
		else $error("justification counts not cleared");
endmodule : ohi_tx_checker
bind ohi_tx_inserter ohi_tx_checker u_chk (.clock, .rst_n, .tx_bus_clock,
	.tx_bus_data, .tx_bus_parity, .cfg, .out_valid, .parity_error,
	.protect_tx_data_oe, .protect_tx_frame_pulse, .protect_tx_frame_pulse_oe,
	.protect_tx_clock_out, .path_user_bit_clock, .path_user_byte_sync,
	.mux_dcc_clock,
	.pj_pos_count, .pj_neg_count);
`default_nettype wire

// >>> test/testbench.sv
// Purpose: frame-level checks of the transmit overhead inserter
// Assumes: stm-0 framing, register sources after reset, serial channels for F2/F3 and DCC
// Notes: bytes are indexed from the last output frame start
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import ohi_pkg::*;
	logic clock, rst_n, bad_par, trace_wr_en, bclk, frm, pay, par, ser;
	logic out_frame, out_payload, out_valid, parity_error;
	logic [6:0] j1_col;
	logic [5:0] trace_wr_addr;
	logic [7:0] trace_wr_data, bdata, out_data;
	logic [7:0] cap [0:809];
	logic [15:0] pos_cnt, neg_cnt;
	logic [7:0] pdata, p_j0;
	logic pfp;
	ohi_cfg_s cfg;
	ohi_ohreg_s oh_regs;
	ohi_rx_s rx;
	int n_mismatch, checks, idx, frames, n_perr;
	ohi_mapper_model u_ohi_mapper_model (.clock, .rst_n, .j1_col, .bad_par,
		.tx_bus_data(bdata), .tx_bus_clock(bclk), .tx_bus_frame_marker(frm),
		.tx_bus_payload_active(pay), .tx_bus_parity(par), .ser_bit(ser));
	// unused protection inputs and spare serial lines held steady
	ohi_tx_inserter u_ohi_tx_inserter (.clock, .rst_n, .tx_bus_data(bdata),
		.tx_bus_clock(bclk), .tx_bus_frame_marker(frm),
		.tx_bus_payload_active(pay), .tx_bus_parity(par), .cfg, .oh_regs,
		.rx, .trace_wr_en, .trace_wr_addr, .trace_wr_data,
		.path_oh_serial_in(ser), .path_user_channel1_in(1'b1),
		.path_user_channel2_in(1'b0), .path_user_bit_clock(),
		.path_user_byte_sync(), .section_oh_serial_in(ser),
		.mux_dcc_serial_in(1'b1), .mux_dcc_clock(),
		.protect_tx_data_in(8'h00), .protect_tx_data(pdata),
		.protect_tx_data_oe(), .protect_tx_frame_pulse_in(1'b0),
		.protect_tx_frame_pulse(pfp), .protect_tx_frame_pulse_oe(),
		.protect_tx_clock_out(), .out_data, .out_frame, .out_payload,
		.out_valid, .parity_error, .pj_pos_count(pos_cnt),
		.pj_neg_count(neg_cnt));
	always #25 clock = ~clock;
	// sampled mid-cycle so design updates have landed
	always @(negedge clock)
	begin
		if (out_valid === 1'b1)
		begin
			if (out_frame === 1'b1 && out_payload === 1'b0)
			begin
				idx = 0;
				frames++;
			end
			else
				idx++;
			if (idx < 810)
				cap[idx] = out_data;
		end
		if (pfp === 1'b1)
			p_j0 = pdata;
		if (parity_error === 1'b1)
			n_perr++;
	end
	task automatic final_report;
		if (n_mismatch == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	task automatic cmp(input string what, input logic [15:0] e,
		input logic [15:0] g);
		checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask : cmp
	task automatic slot(input int off, input logic [7:0] e);
		cmp($sformatf("slot %0d", off), {8'h00, e}, {8'h00, cap[off]});
	endtask : slot
	task automatic wait_frames(input int n);
		int stop;
		stop = frames + n;
		while (frames < stop)
			@(posedge clock);
	endtask : wait_frames
	task automatic trace_write(input logic [5:0] a, input logic [7:0] d);
		@(posedge clock);
		trace_wr_en <= 1'b1;
		trace_wr_addr <= a;
		trace_wr_data <= d;
		@(posedge clock);
		trace_wr_en <= 1'b0;
	endtask : trace_write
	// about eleven frames are needed; this bound is well past that
	initial
	begin
		repeat (95000)
			@(posedge clock);
		n_mismatch++;
		final_report();
	end
	initial
	begin
		clock = 1'b0;
		rst_n = 1'b0;
		bad_par = 1'b0;
		j1_col = 7'h03;
		trace_wr_en = 1'b0;
		trace_wr_addr = 6'h00;
		trace_wr_data = 8'h00;
		cfg = '0;
		oh_regs = {8'h3a, 8'h25, 8'h6e, 8'h5a, 8'ha7, 8'h3c};
		rx = '0;
		idx = 900;
		repeat (2)
			@(posedge clock);
		rst_n <= 1'b1;
		trace_write(6'h00, 8'h8b);
		for (int i = 1; i < 16; i++)
			trace_write(i[5:0], 8'h40 + i[7:0]);
		@(posedge clock);
		bad_par <= 1'b1;
		repeat (8)
			@(posedge clock);
		bad_par <= 1'b0;
		wait_frames(3);
		cmp("parity errors", 16'h0001, n_perr[15:0]);
		slot(359, 8'h5a);
		slot(360, 8'ha7);
		slot(718, 8'h3c);
		slot(181, 8'h3a);
		slot(271, 8'h25);
		slot(631, 8'h6e);
		slot(361, 8'hff);
		slot(541, 8'h00);
		slot(448, 8'hff);
		slot(5, 8'h07);
		@(posedge clock);
		cfg.k2_auto <= 1'b1;
		cfg.g1_auto <= 1'b1;
		cfg.protect_master <= 1'b1;
		rx <= '{f2: 8'h81, f3: 8'h42, dcc: 8'hc3, rei: 4'h9, rdi: 1'b1,
			ms_rdi: 1'b1};
		wait_frames(2);
		slot(360, 8'ha6);
		slot(271, 8'h9d);
		cmp("protect j0", 16'h0002, {8'h00, p_j0});
		@(posedge clock);
		cfg.uneq_en <= 1'b1;
		cfg.fch_src_rx <= 1'b1;
		cfg.dcc_src_rx <= 1'b1;
		rx.ms_rdi <= 1'b0;
		wait_frames(2);
		slot(5, 8'h00);
		slot(181, 8'h3a);
		slot(360, 8'ha0);
		slot(361, 8'h81);
		slot(541, 8'h42);
		slot(448, 8'hc3);
		@(posedge clock);
		j1_col <= 7'h04;
		// serial feeds carry bus bit 0, alternating from an even column
		cfg.c2_src_ser <= 1'b1;
		cfg.k_src_ser <= 1'b1;
		cfg.s1_src_ser <= 1'b1;
		wait_frames(2);
		cmp("positive count", 16'h0001, pos_cnt);
		cmp("negative count", 16'h0000, neg_cnt);
		slot(182, 8'h55);
		slot(359, 8'h55);
		slot(360, 8'h50);
		slot(718, 8'h55);
		@(posedge clock);
		j1_col <= 7'h03;
		wait_frames(2);
		cmp("positive count", 16'h0001, pos_cnt);
		cmp("negative count", 16'h0001, neg_cnt);
		final_report();
	end
endmodule : testbench
`default_nettype wire
